// *** core/gpb_pkg.sv ***
// Constants for the general-purpose pin B decode block.
// Assumes an ISA-style bus sampled synchronously to one clock.
package gpb_pkg;
    // Configuration port I/O addresses
    localparam logic [10:0] ENA_PORT_IO = 11'h250;
    localparam logic [10:0] IDX_PORT_IO = 11'h251;
    localparam logic [10:0] DAT_PORT_IO = 11'h252;
    localparam logic [7:0] ENABLE_KEY = 8'h89;
    // Register indices
    localparam logic [7:0] IDX_ADL = 8'h12;
    localparam logic [7:0] IDX_ADH = 8'h13;
    localparam logic [7:0] IDX_CFG = 8'h15;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] ADL_RST = 8'h00;
    localparam logic [7:0] ADH_RST = 8'h00;
    // Writable bits of the high address register
    localparam logic [7:0] ADH_WMASK = 8'hC7;
    // Field positions of the function register
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int POL_BIT = 4;
    localparam int QRD_BIT = 3;
    localparam int QWR_BIT = 2;
    localparam int INV_B2P = 1;
    localparam int INV_P2B = 0;
    // Field positions of the high address register
    localparam int SIZE_HI = 7;
    localparam int SIZE_LO = 6;
    localparam int AHI_HI = 2;
    // Mode codes
    localparam logic [2:0] MODE_OFF = 3'b000;
    localparam logic [2:0] MODE_OUT = 3'b001;
    localparam logic [2:0] MODE_IN = 3'b010;
    localparam logic [2:0] MODE_IO = 3'b011;

    // Address bits compared for a decode-size code
    function automatic logic [10:0] size_mask(input logic [1:0] size);
        logic [10:0] m;
        m = 11'h7FF;
        unique case (size)
            2'b00: m = 11'h7FF;
            2'b01: m = 11'h7FE;
            2'b10: m = 11'h7FC;
            2'b11: m = 11'h7F8;
        endcase
        return m;
    endfunction
endpackage

// *** core/gpb_match.sv ***
// Address comparator for the pin B decode window.
// Assumes address and programmed values are stable in the clock domain.
`timescale 1ns/1ps
module gpb_match
(
    input wire logic [10:0] sa,
    input wire logic [10:0] match_addr,
    input wire logic [1:0] decode_size,
    output logic hit
);
    logic [10:0] mask;
    always_comb
    begin
        mask = gpb_pkg::size_mask(decode_size);
        hit = ((sa ^ match_addr) & mask) == 11'h000;
    end
endmodule

// *** core/gpb_top.sv ***
// General-purpose pin B: configuration port, decoder and pin logic.
// Assumes ISA strobes sampled synchronously at clk, held several cycles.
`timescale 1ns/1ps
module gpb_top
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [10:0] sa,
    input wire logic aen,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [7:0] sd_in,
    output logic [7:0] sd_out,
    output logic [7:0] sd_oe_n,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n
);
    logic iow_n_q;
    logic ext_en_q;
    logic [7:0] index_q;
    logic [7:0] cfg_q;
    logic [7:0] adl_q;
    logic [7:0] adh_q;
    logic pin_lat_q;
    logic [7:0] sd_out_q;
    logic [7:0] sd_oe_n_q;
    logic pin_out_q;
    logic pin_oe_n_q;
    logic wr_edge;
    logic io_wr;
    logic ena_port_hit;
    logic idx_port_hit;
    logic dat_port_hit;
    logic port_hit;
    logic addr_hit;
    logic gp_hit;
    logic [2:0] mode;
    logic cs_act;
    logic cfg_rd;
    logic data_rd;
    logic data_wr;
    logic [7:0] rd_val;

    gpb_match gpb_match_i
    (
        .sa(sa),
        .match_addr({adh_q[gpb_pkg::AHI_HI:0], adl_q}),
        .decode_size(adh_q[gpb_pkg::SIZE_HI:gpb_pkg::SIZE_LO]),
        .hit(addr_hit)
    );

    always_comb
    begin
        wr_edge = iow_n_q & ~iow_n;
        io_wr = ~aen & wr_edge;
        ena_port_hit = sa == gpb_pkg::ENA_PORT_IO;
        idx_port_hit = sa == gpb_pkg::IDX_PORT_IO;
        dat_port_hit = sa == gpb_pkg::DAT_PORT_IO;
        port_hit = ena_port_hit | idx_port_hit | dat_port_hit;
        gp_hit = ~aen & addr_hit & ~port_hit;
        mode = cfg_q[gpb_pkg::MODE_HI:gpb_pkg::MODE_LO];
        cs_act = 1'b0;
        unique case (cfg_q[gpb_pkg::QRD_BIT:gpb_pkg::QWR_BIT])
            2'b00: cs_act = gp_hit;
            2'b01: cs_act = gp_hit & ~iow_n;
            2'b10: cs_act = gp_hit & ~ior_n;
            2'b11: cs_act = gp_hit & (~iow_n | ~ior_n);
        endcase
        cfg_rd = ~aen & ~ior_n & ext_en_q & (idx_port_hit | dat_port_hit);
        data_rd = gp_hit & ~ior_n & ~mode[2] & mode[1];
        data_wr = gp_hit & wr_edge & ~mode[2] & mode[0];
        rd_val = 8'h00;
        if (idx_port_hit)
            rd_val = index_q;
        else if (index_q == gpb_pkg::IDX_CFG)
            rd_val = cfg_q;
        else if (index_q == gpb_pkg::IDX_ADL)
            rd_val = adl_q;
        else if (index_q == gpb_pkg::IDX_ADH)
            rd_val = adh_q;
    end

    // Write strobe history for edge detection
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            iow_n_q <= 1'b1;
        else
            iow_n_q <= iow_n;
    end

    // Configuration port unlock and index
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_en_q <= 1'b0;
            index_q <= 8'h00;
        end
        else if (io_wr & ena_port_hit)
            ext_en_q <= sd_in == gpb_pkg::ENABLE_KEY;
        else if (io_wr & idx_port_hit & ext_en_q)
            index_q <= sd_in;
    end

    // Configuration registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_q <= gpb_pkg::CFG_RST;
            adl_q <= gpb_pkg::ADL_RST;
            adh_q <= gpb_pkg::ADH_RST;
        end
        else if (io_wr & dat_port_hit & ext_en_q)
        begin
            if (index_q == gpb_pkg::IDX_CFG)
                cfg_q <= sd_in;
            if (index_q == gpb_pkg::IDX_ADL)
                adl_q <= sd_in;
            if (index_q == gpb_pkg::IDX_ADH)
                adh_q <= sd_in & gpb_pkg::ADH_WMASK;
        end
    end

    // Output data latch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pin_lat_q <= 1'b0;
        else if (data_wr)
            pin_lat_q <= sd_in[0] ^ cfg_q[gpb_pkg::INV_B2P];
    end

    // Pin drive
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end
        else if (mode[2])
        begin
            pin_out_q <= cfg_q[gpb_pkg::POL_BIT] ? cs_act
                : ~cs_act;
            pin_oe_n_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= mode[0] & pin_lat_q;
            pin_oe_n_q <= ~mode[0];
        end
    end

    // Data bus drive
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sd_out_q <= 8'h00;
            sd_oe_n_q <= 8'hFF;
        end
        else if (cfg_rd)
        begin
            sd_out_q <= rd_val;
            sd_oe_n_q <= 8'h00;
        end
        else
        begin
            sd_out_q <= {7'h00, pin_in ^ cfg_q[gpb_pkg::INV_P2B]};
            sd_oe_n_q <= data_rd ? 8'hFE : 8'hFF;
        end
    end

    assign sd_out = sd_out_q;
    assign sd_oe_n = sd_oe_n_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;

    a_off_tristate: assert property (
        @(posedge clk) disable iff (!arst_n)
        mode == gpb_pkg::MODE_OFF |=> pin_oe_n_q)
        else $error("pin driven in inactive mode");
    a_out_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        data_wr && mode == gpb_pkg::MODE_OUT ##1 mode == gpb_pkg::MODE_OUT
        |=> pin_out_q == $past(sd_in[0] ^ cfg_q[gpb_pkg::INV_B2P], 2)
        && !pin_oe_n_q)
        else $error("output mode pin value wrong");
    a_in_read: assert property (
        @(posedge clk) disable iff (!arst_n)
        data_rd && !cfg_rd |=> sd_oe_n_q == 8'hFE
        && sd_out_q[0] == $past(pin_in ^ cfg_q[gpb_pkg::INV_P2B]))
        else $error("input read data wrong");
    a_io_read: assert property (
        @(posedge clk) disable iff (!arst_n)
        mode == gpb_pkg::MODE_IO && gp_hit && !ior_n && !cfg_rd
        |=> !sd_oe_n_q[0])
        else $error("io mode read not driven");
    a_cs_level: assert property (
        @(posedge clk) disable iff (!arst_n)
        mode[2] && cs_act |=> pin_out_q == $past(cfg_q[gpb_pkg::POL_BIT])
        && !pin_oe_n_q)
        else $error("select not asserted at set level");
    a_cs_qualify: assert property (
        @(posedge clk) disable iff (!arst_n)
        mode[2] && cfg_q[gpb_pkg::QRD_BIT:gpb_pkg::QWR_BIT] == 2'b10 && ior_n
        |=> pin_out_q != $past(cfg_q[gpb_pkg::POL_BIT]))
        else $error("select asserted without read strobe");
    a_cs_idle: assert property (
        @(posedge clk) disable iff (!arst_n)
        mode[2] && !gp_hit |=> pin_out_q != $past(cfg_q[gpb_pkg::POL_BIT]))
        else $error("select active outside match");
    a_bus_idle: assert property (
        @(posedge clk) disable iff (!arst_n)
        !data_rd && !cfg_rd |=> sd_oe_n_q == 8'hFF)
        else $error("bus driven outside read");
    a_adh_store: assert property (
        @(posedge clk) disable iff (!arst_n)
        io_wr && dat_port_hit && ext_en_q && index_q == gpb_pkg::IDX_ADH
        |=> adh_q == $past(sd_in & gpb_pkg::ADH_WMASK))
        else $error("high address register not stored");
endmodule

// *** verif/gpb_host.sv ***
// ISA host model that runs bus cycles towards the pin B block.
// Assumes one clock; the bench calls cyc for every cycle.
`timescale 1ns/1ps
module gpb_host
(
    input wire logic clk,
    output logic [10:0] sa,
    output logic aen,
    output logic ior_n,
    output logic iow_n,
    output logic [7:0] sd_in,
    input wire logic [7:0] sd_out,
    input wire logic [7:0] sd_oe_n,
    input wire logic pin_out,
    input wire logic pin_oe_n
);
    logic [7:0] hd;
    logic hoe;
    // Undriven bus bits show hd: the cycle's d, inverted once the cycle ends
    assign sd_in = hoe ? hd : (~sd_oe_n & sd_out) | (sd_oe_n & hd);
    initial
    begin
        sa = 11'h000;
        aen = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        hd = 8'h00;
        hoe = 1'b0;
    end
    task automatic cyc(input logic [10:0] a, input logic r, input logic w,
        input logic [7:0] d, output logic [7:0] q, output logic [7:0] e,
        output logic p, output logic o);
        @(posedge clk);
        sa <= a;
        aen <= 1'b0;
        hd <= d;
        hoe <= w;
        @(posedge clk);
        ior_n <= !r;
        iow_n <= !w;
        repeat (3) @(posedge clk);
        // Sample mid-cycle, while strobes still stand
        @(negedge clk);
        q = sd_in;
        e = sd_oe_n;
        p = pin_out;
        o = pin_oe_n;
        @(posedge clk);
        ior_n <= 1'b1;
        iow_n <= 1'b1;
        @(posedge clk);
        aen <= 1'b1;
        hoe <= 1'b0;
        hd <= ~hd;
    endtask
endmodule

// *** verif/gpb_top_tb.sv ***
// Self-checking bench for the pin B decode block.
// Assumes the host model issues every bus cycle.
`timescale 1ns/1ps
module gpb_top_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic pin_in = 1'b0;
    logic aen, ior_n, iow_n, pin_out, pin_oe_n, p, o;
    logic [10:0] sa;
    logic [7:0] sd_in, sd_out, sd_oe_n, q, e;
    int n_mismatch = 0;
    int n_tests = 0;
    int tick = 0;
    int unl = 0, idx = 0, cfg = 0, adl = 0, adh = 0, lat = 0;
    always #5 clk = ~clk;
    gpb_top gpb_top_i (.clk(clk), .arst_n(arst_n), .sa(sa), .aen(aen),
        .ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out),
        .sd_oe_n(sd_oe_n), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    gpb_host gpb_host_i (.clk(clk), .sa(sa), .aen(aen), .ior_n(ior_n),
        .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    task automatic end_sim();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        tick <= tick + 1;
        if (tick == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    function automatic int hit(input int a);
        int m;
        m = 11'h7FF & ~((1 << (adh >> 6)) - 1);
        return ((a & m) == ((((adh & 7) << 8) | adl) & m)) && (a < 11'h250
            || a > 11'h252);
    endfunction
    task automatic op(input int a, input int r, input int w, input int d);
        int x, md, h, s;
        gpb_host_i.cyc(a[10:0], r[0], w[0], d[7:0], q, e, p, o);
        md = cfg >> 5;
        h = hit(a);
        if (r && unl && (a == gpb_pkg::IDX_PORT_IO
            || a == gpb_pkg::DAT_PORT_IO))
        begin
            x = a == gpb_pkg::IDX_PORT_IO ? idx : idx == 8'h12 ? adl :
                idx == 8'h13 ? adh : idx == 8'h15 ? cfg : 0;
            chk(e, 8'h00);
            chk(q, x);
        end
        else if (r && h && md[1] && !md[2])
        begin
            chk(e, 8'hFE);
            chk(q[0], pin_in ^ cfg[0]);
        end
        else
            chk(e, 8'hFF);
        if (w && a == gpb_pkg::ENA_PORT_IO)
            unl = d == 8'h89;
        if (w && unl && a == gpb_pkg::IDX_PORT_IO)
            idx = d;
        if (w && unl && a == gpb_pkg::DAT_PORT_IO)
        begin
            if (idx == 8'h12)
                adl = d;
            if (idx == 8'h13)
                adh = d & 8'hC7;
            if (idx == 8'h15)
                cfg = d;
        end
        if (w && h && md[0] && !md[2])
            lat = d[0] ^ cfg[1];
        md = cfg >> 5;
        s = (cfg >> 2) & 3;
        x = h && (s == 0 || s == 1 && w || s == 2 && r || s == 3 && (r || w));
        if (md >= 4)
        begin
            chk(o, 8'h00);
            chk(p, x ? cfg[4] : !cfg[4]);
        end
        else
        begin
            chk(o, !md[0]);
            if (md != 2)
                chk(p, md[0] ? lat : 0);
        end
    endtask
    task automatic wreg(input int i, input int v);
        op(gpb_pkg::IDX_PORT_IO, 0, 1, i);
        op(gpb_pkg::DAT_PORT_IO, 0, 1, v);
    endtask
    initial
    begin
        void'($urandom(87924));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(pin_oe_n, 8'h01);
        op(gpb_pkg::DAT_PORT_IO, 1, 0, 0);
        op(gpb_pkg::ENA_PORT_IO, 0, 1, 8'h89);
        for (int i = 8'h12; i < 8'h16; i++)
        begin
            op(gpb_pkg::IDX_PORT_IO, 0, 1, i);
            op(gpb_pkg::DAT_PORT_IO, 1, 0, $urandom);
        end
        op(gpb_pkg::IDX_PORT_IO, 1, 0, 0);
        wreg(8'h12, 8'hA8);
        wreg(8'h13, 8'hFB);
        op(gpb_pkg::DAT_PORT_IO, 1, 0, 0);
        for (int m = 0; m < 16; m++)
        begin
            wreg(8'h15, ((m >> 2) << 5) | (m & 3));
            pin_in <= 1'($urandom);
            op(11'h3A8 + $urandom % 8, 0, 1, $urandom);
            op(11'h3A8 + $urandom % 8, 1, 0, $urandom);
        end
        for (int m = 0; m < 8; m++)
        begin
            wreg(8'h15, 8'h80 | (m << 2) | ($urandom & 8'h63));
            op(11'h3A8 + $urandom % 8, 1, 0, $urandom);
            op(11'h3A8 + $urandom % 8, 0, 1, $urandom);
            op(11'h3A8 + $urandom % 8, 0, 0, $urandom);
            op(11'h2A8, 1, 0, $urandom);
        end
        wreg(8'h15, 8'h80);
        for (int z = 0; z < 4; z++)
        begin
            wreg(8'h13, (z << 6) | 3);
            op(11'h3A8 + (1 << z) - 1, 0, 0, 0);
            op(11'h3A8 + (1 << z), 0, 0, 0);
        end
        op(gpb_pkg::ENA_PORT_IO, 0, 1, 8'h88);
        wreg(8'h15, 8'h00);
        op(gpb_pkg::IDX_PORT_IO, 1, 0, 0);
        // Reset in mid-run clears every register and the latch
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        unl = 0;
        idx = 0;
        cfg = 0;
        adl = 0;
        adh = 0;
        lat = 0;
        op(gpb_pkg::ENA_PORT_IO, 0, 1, 8'h89);
        op(gpb_pkg::IDX_PORT_IO, 0, 1, 8'h13);
        op(gpb_pkg::DAT_PORT_IO, 1, 0, 0);
        op(gpb_pkg::IDX_PORT_IO, 0, 1, 8'h15);
        op(gpb_pkg::DAT_PORT_IO, 1, 0, 0);
        end_sim();
    end
endmodule
